/* File: hw/fpst_transfer_unit.sv */
// Purpose: Register stack with load, store, exchange, conditional move and
//          constant push, one command per clock.
// Assumes: Core resolves memory addresses and hands over operand data.
// Notes:   Real stores flush results below the normal range to zero.
`timescale 1ns/1ps
module fpst_transfer_unit
  import fpst_pkg::*;
#(
  parameter bit CMOV_SUPPORTED = 1'b1
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire fpst_cmd_t   cmd,
  input  wire fpst_flags_t int_flags,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output fpst_rsp_t        rsp_r,
  output logic [31:0]      reg_rdata_r,
  output logic [2:0]       top_r,
  output logic [7:0]       tag_r
);

  fpst_ext_t   stk_r [8];
  logic [1:0]  round_r;
  logic        imask_r;
  logic        inv_flag_r;

  function automatic logic [6:0] lzc64(input logic [63:0] v);
    logic [6:0] n;
    logic       hit;
    n = '0;
    hit = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      if (v[i]) hit = 1'b1;
      else if (!hit) n = n + 7'd1;
    end
    return n;
  endfunction

  function automatic fpst_ext_t make_ext(input logic s, input logic [63:0] m,
                                         input int e);
    fpst_ext_t  x;
    logic [6:0] z;
    x = '0;
    x.sign = s;
    z = lzc64(m);
    if (m != '0) begin
      x.sig = m << z;
      x.exp = 15'(e - int'(z));
    end
    return x;
  endfunction

  function automatic fpst_ext_t real_to_ext(input logic [63:0] m,
                                            input logic dbl);
    logic        s;
    int          e;
    logic [51:0] f;
    logic        top_exp;
    fpst_ext_t   x;
    x = '0;
    if (dbl) begin
      s = m[63];
      e = int'(m[62:52]);
      f = m[51:0];
      top_exp = &m[62:52];
    end else begin
      s = m[31];
      e = int'(m[30:23]);
      f = {m[22:0], 29'h0};
      top_exp = &m[30:23];
    end
    if (top_exp) begin
      x.sign = s;
      x.exp = EXP_MAX;
      x.sig = {1'b1, f, 11'h0};
    end else begin
      // Denormal sources normalise into the wider exponent range
      x = make_ext(s, {e != 0, f, 11'h0},
                   (e == 0 ? 1 : e) - (dbl ? DBL_BIAS : SGL_BIAS) + EXT_BIAS);
    end
    return x;
  endfunction

  function automatic fpst_ext_t int_to_ext(input logic [63:0] v);
    return make_ext(v[63], v[63] ? (~v + 64'h1) : v, EXT_BIAS + 63);
  endfunction

  function automatic fpst_ext_t bcd_to_ext(input logic [79:0] b);
    logic [63:0] acc;
    acc = '0;
    for (int i = 17; i >= 0; i--)
      acc = (acc << 3) + (acc << 1) + 64'(b[i*4 +: 4]);
    return make_ext(b[79], acc, EXT_BIAS + 63);
  endfunction

  function automatic logic rnd_up(input logic [1:0] mode, input logic s,
                                  input logic lsb, input logic g,
                                  input logic sticky);
    case (mode)
      ROUND_NEAR: return g & (sticky | lsb);
      ROUND_DOWN: return s & (g | sticky);
      ROUND_UP:   return !s & (g | sticky);
      default:    return 1'b0;
    endcase
  endfunction

  // Bit 64 flags overflow; low bits hold the rounded magnitude
  function automatic logic [64:0] ext_to_int(input fpst_ext_t x,
                                             input logic [1:0] mode);
    int           e;
    logic [127:0] p;
    logic [63:0]  ip;
    logic         g;
    logic         sticky;
    logic         up;
    logic [64:0]  r;
    r = '0;
    ip = '0;
    g = 1'b0;
    sticky = 1'b1;
    e = int'(x.exp) - EXT_BIAS;
    if (x.exp == EXP_MAX || e > 63) r[64] = 1'b1;
    else if (x.sig != '0) begin
      if (e >= -1) begin
        p = {64'h0, x.sig} << (e + 1);
        ip = p[127:64];
        g = p[63];
        sticky = |p[62:0];
      end
      up = rnd_up(mode, x.sign, ip[0], g, sticky);
      r[64] = up & (&ip);
      r[63:0] = ip + 64'(up);
    end
    return r;
  endfunction

  function automatic int int_width(input logic [1:0] fmt);
    return (fmt == FMT_WORD) ? 16 : (fmt == FMT_SHORT) ? 32 : 64;
  endfunction

  function automatic logic [63:0] int_indef(input logic [1:0] fmt);
    return 64'h1 << (int_width(fmt) - 1);
  endfunction

  function automatic logic [63:0] ext_to_real(input fpst_ext_t x,
                                              input logic dbl,
                                              input logic [1:0] mode);
    int          e;
    int          emax;
    logic [51:0] m;
    logic        carry;
    logic        up;
    emax = dbl ? DBL_EMAX : SGL_EMAX;
    m = dbl ? x.sig[62:11] : {29'h0, x.sig[62:40]};
    e = int'(x.exp) - EXT_BIAS + (dbl ? DBL_BIAS : SGL_BIAS);
    up = rnd_up(mode, x.sign, m[0], dbl ? x.sig[10] : x.sig[39],
                dbl ? |x.sig[9:0] : |x.sig[38:0]);
    carry = up & (dbl ? &m : &m[22:0]);
    if (x.exp == EXP_MAX) begin
      e = emax;
      // Keep a lost NaN payload from turning into infinity
      if (|x.sig[62:0])
        m = m | (dbl ? 52'h8_0000_0000_0000 : 52'h40_0000);
    end else if (x.sig == '0 || e <= 0) begin
      e = 0;
      m = '0;
    end else begin
      m = (m + 52'(up)) & (dbl ? 52'hF_FFFF_FFFF_FFFF : 52'h7F_FFFF);
      e = e + int'(carry);
      if (e >= emax) begin
        e = emax;
        m = '0;
      end
    end
    return dbl ? {x.sign, 11'(e), m} : {32'h0, x.sign, 8'(e), m[22:0]};
  endfunction

  function automatic logic [71:0] bin_to_bcd(input logic [63:0] v);
    logic [71:0] d;
    d = '0;
    for (int i = 63; i >= 0; i--) begin
      for (int j = 0; j < 18; j++)
        if (d[j*4 +: 4] >= 4'h5) d[j*4 +: 4] = d[j*4 +: 4] + 4'h3;
      d = {d[70:0], v[i]};
    end
    return d;
  endfunction

  function automatic logic cond_true(input logic [2:0] sel,
                                     input fpst_flags_t f);
    case (sel)
      COND_BELOW:    return f.carry_flag;
      COND_NBELOW:   return !f.carry_flag;
      COND_EQUAL:    return f.zero_flag;
      COND_NEQUAL:   return !f.zero_flag;
      COND_BELOW_EQ: return f.carry_flag | f.zero_flag;
      COND_ABOVE:    return !(f.carry_flag | f.zero_flag);
      COND_UNORD:    return f.parity_flag;
      default:       return !f.parity_flag;
    endcase
  endfunction

  function automatic fpst_ext_t const_ext(input logic [2:0] sel,
                                          input logic [1:0] mode);
    fpst_const_t c;
    fpst_ext_t   x;
    case (sel)
      K_ONE:   c = C_ONE;
      K_PI:    c = C_PI;
      K_L2TEN: c = C_L2TEN;
      K_L2E:   c = C_L2E;
      K_LG2:   c = C_LG2;
      K_LN2:   c = C_LN2;
      default: c = C_ZERO;
    endcase
    x.sign = 1'b0;
    x.exp = c.exp;
    // No stored constant has an all-ones significand, so no carry out
    x.sig = c.sig[71:8] + 64'(rnd_up(mode, 1'b0, c.sig[8], c.sig[7],
                                     |c.sig[6:0]));
    return x;
  endfunction

  logic        go;
  logic [2:0]  new_top;
  logic [2:0]  rel_idx;
  fpst_ext_t   top_val;
  fpst_ext_t   rel_val;
  logic        push;
  fpst_ext_t   push_val;
  logic        pop;
  logic        wa_en;
  logic [2:0]  wa_idx;
  fpst_ext_t   wa_val;
  logic        wa_tag;
  logic        wb_en;
  fpst_ext_t   wb_val;
  logic        wb_tag;
  logic        inv;
  logic        bad;
  logic [64:0] ival;
  logic [63:0] sval;
  fpst_rsp_t   rsp_nxt;

  assign go      = cmd.valid;
  assign top_val = stk_r[top_r];
  assign rel_idx = top_r + cmd.idx;
  assign rel_val = stk_r[rel_idx];
  assign new_top = top_r - 3'd1;

  always_comb begin
    push = 1'b0;
    push_val = '0;
    pop = 1'b0;
    wa_en = 1'b0;
    wa_idx = top_r;
    wa_val = '0;
    wa_tag = 1'b0;
    wb_en = 1'b0;
    wb_val = '0;
    wb_tag = 1'b0;
    inv = 1'b0;
    bad = 1'b0;
    rsp_nxt = '0;
    ival = ext_to_int(top_val, round_r);
    sval = top_val.sign ? (~ival[63:0] + 64'h1) : ival[63:0];
    // Command carries no immediate field; data is register or memory
    if (go) begin
      case (cmd.op)
        OP_LOAD_REAL: begin
          push = 1'b1;
          if (cmd.use_reg) begin
            push_val = rel_val;
            inv = !tag_r[rel_idx];
          end else if (cmd.fmt == FMT_EXT) push_val = cmd.mem;
          else push_val = real_to_ext(cmd.mem[63:0],
                                      cmd.fmt == FMT_DOUBLE);
        end
        OP_LOAD_INT: begin
          push = 1'b1;
          case (cmd.fmt)
            FMT_WORD:  push_val = int_to_ext({{48{cmd.mem[15]}},
                                              cmd.mem[15:0]});
            FMT_SHORT: push_val = int_to_ext({{32{cmd.mem[31]}},
                                              cmd.mem[31:0]});
            default:   push_val = int_to_ext(cmd.mem[63:0]);
          endcase
        end
        OP_LOAD_BCD: begin
          push = 1'b1;
          push_val = bcd_to_ext(cmd.mem);
        end
        OP_STORE_REAL: begin
          inv = !tag_r[top_r];
          pop = cmd.pop;
          if (cmd.use_reg) begin
            wa_en = 1'b1;
            wa_idx = rel_idx;
            wa_val = top_val;
            wa_tag = tag_r[top_r];
          end else begin
            rsp_nxt.wr = 1'b1;
            rsp_nxt.data = (cmd.fmt == FMT_EXT) ? top_val :
              {16'h0, ext_to_real(top_val, cmd.fmt == FMT_DOUBLE, round_r)};
          end
        end
        OP_STORE_INT: begin
          bad = ival[64] || !tag_r[top_r] ||
                ival[63:0] > (int_indef(cmd.fmt) - 64'(!top_val.sign));
          inv = bad;
          rsp_nxt.wr = !bad || imask_r;
          pop = cmd.pop && (!bad || imask_r);
          if (bad) rsp_nxt.data = {16'h0, int_indef(cmd.fmt)};
          else rsp_nxt.data = {16'h0, sval & ~({64{1'b1}} <<
                               (int_width(cmd.fmt) - 1) << 1)};
        end
        OP_STORE_BCD: begin
          bad = ival[64] || !tag_r[top_r] || ival[63:0] >= BCD_LIMIT;
          inv = bad;
          rsp_nxt.wr = !bad || imask_r;
          pop = !bad || imask_r;
          rsp_nxt.data = bad ? BCD_INDEF :
            {top_val.sign, 7'h0, bin_to_bcd(ival[63:0])};
        end
        OP_EXCHANGE: begin
          wa_en = 1'b1;
          wa_idx = rel_idx;
          wa_val = top_val;
          wa_tag = tag_r[top_r];
          wb_en = 1'b1;
          wb_val = rel_val;
          wb_tag = tag_r[rel_idx];
        end
        OP_COND_MOVE: begin
          // Unsupported builds treat the move as a no-op
          if (CMOV_SUPPORTED && cond_true(cmd.sel, int_flags)) begin
            wb_en = 1'b1;
            wb_val = rel_val;
            wb_tag = tag_r[rel_idx];
          end
        end
        OP_PUSH_CONST: begin
          push = 1'b1;
          push_val = const_ext(cmd.sel, round_r);
        end
        default: ;
      endcase
      // Overwriting a live register is a stack overflow
      if (push && tag_r[new_top]) inv = 1'b1;
      rsp_nxt.valid = 1'b1;
      rsp_nxt.invalid = inv;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) stk_r[i] <= '0;
    end else begin
      if (push) stk_r[new_top] <= push_val;
      if (wa_en) stk_r[wa_idx] <= wa_val;
      if (wb_en) stk_r[top_r] <= wb_val;
    end
  end

  // Pop clears last so a copy into the top before popping still empties it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      top_r <= '0;
      tag_r <= '0;
    end else begin
      if (wa_en) tag_r[wa_idx] <= wa_tag;
      if (wb_en) tag_r[top_r] <= wb_tag;
      if (push) begin
        top_r <= new_top;
        tag_r[new_top] <= 1'b1;
      end
      if (pop) begin
        top_r <= top_r + 3'd1;
        tag_r[top_r] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) rsp_r <= '0;
    else rsp_r <= rsp_nxt;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      round_r <= ROUND_RESET;
      imask_r <= IMASK_RESET;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      round_r <= reg_wdata[CTRL_ROUND_LSB +: 2];
      imask_r <= reg_wdata[CTRL_IMASK_BIT];
    end
  end

  // Set beats a same-cycle write-one-to-clear
  always_ff @(posedge clock) begin
    if (sys_rst) inv_flag_r <= 1'b0;
    else if (go && inv) inv_flag_r <= 1'b1;
    else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_INV_BIT])
      inv_flag_r <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) reg_rdata_r <= '0;
    else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:    reg_rdata_r <= 32'({imask_r, round_r});
        REG_STATUS:  reg_rdata_r <= 32'({inv_flag_r, top_r});
        REG_TAGS:    reg_rdata_r <= 32'(tag_r);
        REG_FEATURE: reg_rdata_r <= 32'(CMOV_SUPPORTED);
        default:     reg_rdata_r <= '0;
      endcase
    end else reg_rdata_r <= '0;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence push_seq;
    go && cmd.op inside {OP_LOAD_REAL, OP_LOAD_INT, OP_LOAD_BCD,
                         OP_PUSH_CONST};
  endsequence

  sequence pi_near_seq;
    go && cmd.op == OP_PUSH_CONST && cmd.sel == K_PI &&
    round_r == ROUND_NEAR;
  endsequence

  push_tag_a: assert property (push_seq |=>
    top_r == $past(top_r) - 3'd1 && tag_r[top_r] && rsp_r.valid)
    else $error("push did not move top or tag new entry");
  pop_top_a: assert property (pop |=>
    top_r == $past(top_r) + 3'd1 && !tag_r[$past(top_r)])
    else $error("pop did not empty top and advance pointer");
  store_keep_a: assert property (
    go && cmd.op == OP_STORE_INT && !cmd.pop |=> top_r == $past(top_r))
    else $error("store without pop changed the stack pointer");
  cmov_hold_a: assert property (
    go && cmd.op == OP_COND_MOVE && !cond_true(cmd.sel, int_flags)
    |=> stk_r[top_r] == $past(top_val))
    else $error("failed conditional move altered the top");
  int_indef_a: assert property (
    go && cmd.op == OP_STORE_INT && bad && imask_r
    |=> rsp_r.wr && rsp_r.invalid &&
        rsp_r.data[63:0] == int_indef($past(cmd.fmt)))
    else $error("masked invalid integer store lacks indefinite");
  bcd_indef_a: assert property (
    go && cmd.op == OP_STORE_BCD && bad && imask_r
    |=> rsp_r.wr && rsp_r.data == BCD_INDEF &&
        top_r == $past(top_r) + 3'd1)
    else $error("masked invalid decimal store lacks indefinite");
  exch_swap_a: assert property (
    go && cmd.op == OP_EXCHANGE |=> stk_r[top_r] == $past(rel_val) &&
    stk_r[$past(rel_idx)] == $past(top_val) || $past(cmd.idx) == 3'd0)
    else $error("exchange did not swap entries");
  pi_round_a: assert property (pi_near_seq |=>
    stk_r[top_r].sig == C_PI.sig[71:8] + 64'h1)
    else $error("pi not rounded to nearest");
  cmov_feat_a: assert property (
    reg_rd && reg_addr == REG_FEATURE |=> reg_rdata_r[0] == CMOV_SUPPORTED)
    else $error("feature bit does not report conditional move");

endmodule

/* File: hw/fpst_pkg.sv */
// Purpose: Shared types and constants for the stack transfer unit.
// Assumes: Stack entries hold extended-real values (sign, 15b exp, 64b sig).
// Notes:   Constant significands keep 8 extra bits for correct rounding.
// Behaviour
// - Operands come only from the register stack or memory, never immediate.
// - Register operands are chosen relative to the stack top.
// - Memory operands may use any integer addressing mode.
// - Stack registers hold values in extended-real format.
// - Real load pushes a memory single or double converted to extended.
// - Real load may push a copy of a selected stack register.
// - Integer and packed-decimal loads convert to extended and push.
// - Real and integer stores write converted top value, stack unchanged.
// - Store-and-pop variants write the converted top, then pop.
// - Pop marks the top register empty and adds one to the pointer.
// - Real store-and-pop may copy the top into a stack register.
// - Exchange swaps a selected register with the top register.
// - Conditional move copies selected register to top only if true.
// - Conditions come from carry, zero and parity integer flags.
// - Conditional-move support is reported in feature information.
// - Seven constant loads push zero, one, pi and four logarithms.
// - Constants keep 64-bit significands, held wider internally.
// - Constants are rounded to extended under the rounding control.
// - Masked invalid integer store writes sign-bit-only indefinite.
// - Masked invalid packed-decimal store writes decimal indefinite.
// - Packed decimal is ten bytes: eighteen digits then sign bit.
package fpst_pkg;

  typedef struct packed {
    logic        sign;
    logic [14:0] exp;
    logic [63:0] sig;
  } fpst_ext_t;

  typedef enum logic [3:0] {
    OP_NONE       = 4'h0,
    OP_LOAD_REAL  = 4'h1,
    OP_LOAD_INT   = 4'h2,
    OP_LOAD_BCD   = 4'h3,
    OP_STORE_REAL = 4'h4,
    OP_STORE_INT  = 4'h5,
    OP_STORE_BCD  = 4'h6,
    OP_EXCHANGE   = 4'h7,
    OP_COND_MOVE  = 4'h8,
    OP_PUSH_CONST = 4'h9
  } fpst_op_t;

  typedef struct packed {
    logic        valid;
    fpst_op_t    op;
    logic [1:0]  fmt;
    logic        pop;
    logic        use_reg;
    logic [2:0]  idx;
    logic [2:0]  sel;
    logic [79:0] mem;
  } fpst_cmd_t;

  typedef struct packed {
    logic carry_flag;
    logic zero_flag;
    logic parity_flag;
  } fpst_flags_t;

  typedef struct packed {
    logic        valid;
    logic        wr;
    logic        invalid;
    logic [79:0] data;
  } fpst_rsp_t;

  typedef struct packed {
    logic [14:0] exp;
    logic [71:0] sig;
  } fpst_const_t;

  localparam logic [1:0] FMT_SINGLE = 2'h0;
  localparam logic [1:0] FMT_DOUBLE = 2'h1;
  localparam logic [1:0] FMT_EXT    = 2'h2;
  localparam logic [1:0] FMT_WORD   = 2'h0;
  localparam logic [1:0] FMT_SHORT  = 2'h1;
  localparam logic [1:0] FMT_LONG   = 2'h2;

  localparam logic [2:0] COND_BELOW    = 3'h0;
  localparam logic [2:0] COND_NBELOW   = 3'h1;
  localparam logic [2:0] COND_EQUAL    = 3'h2;
  localparam logic [2:0] COND_NEQUAL   = 3'h3;
  localparam logic [2:0] COND_BELOW_EQ = 3'h4;
  localparam logic [2:0] COND_ABOVE    = 3'h5;
  localparam logic [2:0] COND_UNORD    = 3'h6;
  localparam logic [2:0] COND_ORD      = 3'h7;

  localparam logic [2:0] K_ZERO  = 3'h0;
  localparam logic [2:0] K_ONE   = 3'h1;
  localparam logic [2:0] K_PI    = 3'h2;
  localparam logic [2:0] K_L2TEN = 3'h3;
  localparam logic [2:0] K_L2E   = 3'h4;
  localparam logic [2:0] K_LG2   = 3'h5;
  localparam logic [2:0] K_LN2   = 3'h6;

  localparam logic [1:0] ROUND_NEAR = 2'h0;
  localparam logic [1:0] ROUND_DOWN = 2'h1;
  localparam logic [1:0] ROUND_UP   = 2'h2;
  localparam logic [1:0] ROUND_ZERO = 2'h3;

  localparam logic [3:0]  REG_CTRL    = 4'h0;
  localparam logic [3:0]  REG_STATUS  = 4'h4;
  localparam logic [3:0]  REG_TAGS    = 4'h8;
  localparam logic [3:0]  REG_FEATURE = 4'hC;
  localparam int          CTRL_ROUND_LSB = 0;
  localparam int          CTRL_IMASK_BIT = 2;
  localparam int          STAT_TOP_LSB   = 0;
  localparam int          STAT_INV_BIT   = 3;
  localparam logic [1:0]  ROUND_RESET    = 2'h0;
  localparam logic        IMASK_RESET    = 1'b1;

  localparam int          EXT_BIAS = 16383;
  localparam int          DBL_BIAS = 1023;
  localparam int          SGL_BIAS = 127;
  localparam int          DBL_EMAX = 2047;
  localparam int          SGL_EMAX = 255;
  localparam logic [14:0] EXP_MAX  = 15'h7FFF;
  localparam logic [63:0] BCD_LIMIT = 64'h0DE0_B6B3_A764_0000;
  localparam logic [79:0] BCD_INDEF = 80'hFFFF_C000_0000_0000_0000;

  localparam fpst_const_t C_ZERO  = '{15'h0000, 72'h0};
  localparam fpst_const_t C_ONE   = '{15'h3FFF, 72'h80_0000_0000_0000_0000};
  localparam fpst_const_t C_PI    = '{15'h4000, 72'hC9_0FDA_A221_68C2_34C4};
  localparam fpst_const_t C_L2TEN = '{15'h4000, 72'hD4_9A78_4BCD_1B8A_FE49};
  localparam fpst_const_t C_L2E   = '{15'h3FFF, 72'hB8_AA3B_295C_17F0_BBBE};
  localparam fpst_const_t C_LG2   = '{15'h3FFD, 72'h9A_209A_84FB_CFF7_988F};
  localparam fpst_const_t C_LN2   = '{15'h3FFE, 72'hB1_7217_F7D1_CF79_ABC9};

endpackage

/* File: test/fpst_core_model.sv */
// Purpose: Core-side issue model for the stack transfer unit.
// Assumes: One command in flight, answered on the following edge.
// Notes:   An idle cycle between commands keeps each strobe a clean pulse.
`timescale 1ns/1ps
module fpst_core_model
  import fpst_pkg::*;
(
  input  wire logic      clock,
  input  wire fpst_rsp_t rsp_r,
  output fpst_cmd_t      cmd,
  output fpst_flags_t    int_flags
);
  fpst_rsp_t got;
  initial begin
    cmd = '0;
    int_flags = '0;
  end
  // Operands only by stack offset or memory word, no immediate field
  task automatic issue(input fpst_cmd_t c, input fpst_flags_t f);
    @(posedge clock);
    cmd <= c;
    int_flags <= f;
    @(posedge clock);
    cmd <= '0;
    #1;
    got = rsp_r;
  endtask
endmodule

/* File: test/test_fp_stack_transfer_unit.sv */
// Purpose: Self-checking bench for the stack transfer unit.
// Assumes: Default feature set, invalid masked after reset.
// Notes:   Stack pointer and tags are tracked here and checked every command.
`timescale 1ns/1ps
module test_fp_stack_transfer_unit
  import fpst_pkg::*;
;
  localparam logic [79:0] ONE  = 80'h3FFF_8000_0000_0000_0000;
  localparam logic [79:0] HALF = 80'h3FFF_C000_0000_0000_0000;
  localparam logic [79:0] FIVE = 80'h4001_A000_0000_0000_0000;
  localparam logic [79:0] KV [7] = '{80'h0, ONE,
    80'h4000_C90F_DAA2_2168_C235, 80'h4000_D49A_784B_CD1B_8AFE,
    80'h3FFF_B8AA_3B29_5C17_F0BC, 80'h3FFD_9A20_9A84_FBCF_F799,
    80'h3FFE_B172_17F7_D1CF_79AC};
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  fpst_cmd_t   cmd;
  fpst_flags_t int_flags;
  fpst_flags_t fl = '0;
  fpst_rsp_t   rsp_r;
  logic [31:0] reg_rdata_r;
  logic [2:0]  top_r;
  logic [7:0]  tag_r;
  logic [2:0]  t = 3'h0;
  logic [7:0]  tg = 8'h00;
  logic [2:0]  ix;
  logic [79:0] cur;
  int          n_errors = 0;
  int          cmp_count = 0;

  initial begin
    forever #25 clock = ~clock;
  end
  fpst_transfer_unit DUT (.clock(clock), .sys_rst(sys_rst), .cmd(cmd),
    .int_flags(int_flags), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .rsp_r(rsp_r),
    .reg_rdata_r(reg_rdata_r), .top_r(top_r), .tag_r(tag_r));
  fpst_core_model core (.clock(clock), .rsp_r(rsp_r), .cmd(cmd),
    .int_flags(int_flags));

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [79:0] g, input logic [79:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic op(input fpst_op_t o, input logic [1:0] f, input logic p,
      input logic u, input logic [2:0] i, input logic [2:0] s,
      input logic [79:0] m);
    core.issue(fpst_cmd_t'{1'b1, o, f, p, u, i, s, m}, fl);
    if (o inside {OP_LOAD_REAL, OP_LOAD_INT, OP_LOAD_BCD, OP_PUSH_CONST}) begin
      t = t - 3'h1;
      tg[t] = 1'b1;
    end else if (p) begin
      tg[t] = 1'b0;
      t = t + 3'h1;
    end
    chk({79'h0, core.got.valid}, 80'h1);
    chk({77'h0, top_r}, {77'h0, t});
    chk({72'h0, tag_r}, {72'h0, tg});
  endtask
  task automatic st(input logic p, input logic [79:0] e);
    op(OP_STORE_REAL, FMT_EXT, p, 1'b0, 3'h0, 3'h0, 80'h0);
    chk(core.got.data, e);
    chk({79'h0, core.got.wr}, 80'h1);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk({48'h0, reg_rdata_r}, {48'h0, e});
  endtask
  function automatic logic cond_ok(input logic [2:0] c, input fpst_flags_t f);
    logic       be;
    logic [7:0] v;
    be = f.carry_flag | f.zero_flag;
    v = {~f.parity_flag, f.parity_flag, ~be, be, ~f.zero_flag,
         f.zero_flag, ~f.carry_flag, f.carry_flag};
    return v[c];
  endfunction

  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    rd_reg(REG_CTRL, 32'h4);
    rd_reg(REG_FEATURE, 32'h1);
    rd_reg(4'h2, 32'h0);
    $display("test registers done");
    op(OP_PUSH_CONST, 2'h0, 1'b0, 1'b0, 3'h0, K_ONE, 80'h0);
    st(1'b0, ONE);
    op(OP_LOAD_INT, FMT_SHORT, 1'b0, 1'b0, 3'h0, 3'h0, 80'h5);
    st(1'b0, FIVE);
    op(OP_LOAD_REAL, FMT_SINGLE, 1'b0, 1'b0, 3'h0, 3'h0, 80'h3FC0_0000);
    st(1'b0, HALF);
    op(OP_EXCHANGE, 2'h0, 1'b0, 1'b0, 3'h2, 3'h0, 80'h0);
    st(1'b0, ONE);
    op(OP_LOAD_REAL, FMT_EXT, 1'b0, 1'b1, 3'h2, 3'h0, 80'h0);
    op(OP_STORE_REAL, FMT_EXT, 1'b1, 1'b1, 3'h1, 3'h0, 80'h0);
    st(1'b0, HALF);
    op(OP_STORE_REAL, FMT_SINGLE, 1'b0, 1'b0, 3'h0, 3'h0, 80'h0);
    chk(core.got.data, 80'h3FC0_0000);
    op(OP_STORE_REAL, FMT_DOUBLE, 1'b0, 1'b0, 3'h0, 3'h0, 80'h0);
    chk(core.got.data, 80'h3FF8_0000_0000_0000);
    op(OP_LOAD_REAL, FMT_DOUBLE, 1'b0, 1'b0, 3'h0, 3'h0,
       80'h4014_0000_0000_0000);
    st(1'b1, FIVE);
    $display("test transfers done");
    cur = HALF;
    // Flag patterns carry, zero, parity, none tell an or from an and
    for (int k = 0; k < 32; k++) begin
      fl = fpst_flags_t'(3'h4 >> (k / 8));
      ix = (cur === FIVE) ? 3'h2 : 3'h1;
      op(OP_COND_MOVE, 2'h0, 1'b0, 1'b0, ix, 3'(k), 80'h0);
      if (cond_ok(3'(k), fl)) cur = (ix == 3'h1) ? FIVE : HALF;
      st(1'b0, cur);
    end
    $display("test conditional moves done");
    wr_reg(REG_CTRL, 32'h7);
    op(OP_PUSH_CONST, 2'h0, 1'b0, 1'b0, 3'h0, K_PI, 80'h0);
    st(1'b1, 80'h4000_C90F_DAA2_2168_C234);
    wr_reg(REG_CTRL, 32'h4);
    for (int k = 0; k < 7; k++) begin
      op(OP_PUSH_CONST, 2'h0, 1'b0, 1'b0, 3'h0, 3'(k), 80'h0);
      st(1'b1, KV[k]);
    end
    $display("test constants done");
    op(OP_LOAD_INT, FMT_WORD, 1'b0, 1'b0, 3'h0, 3'h0, 80'hFFFB);
    op(OP_STORE_INT, FMT_SHORT, 1'b0, 1'b0, 3'h0, 3'h0, 80'h0);
    chk(core.got.data, 80'hFFFF_FFFB);
    op(OP_STORE_INT, FMT_SHORT, 1'b1, 1'b0, 3'h0, 3'h0, 80'h0);
    chk(core.got.data, 80'hFFFF_FFFB);
    op(OP_LOAD_INT, FMT_LONG, 1'b0, 1'b0, 3'h0, 3'h0, 80'h1_0000_0000);
    op(OP_STORE_INT, FMT_WORD, 1'b1, 1'b0, 3'h0, 3'h0, 80'h0);
    chk({core.got.invalid, core.got.data[78:0]}, {1'b1, 79'h8000});
    rd_reg(REG_STATUS, {28'h0, 1'b1, t});
    op(OP_LOAD_BCD, 2'h0, 1'b0, 1'b0, 3'h0, 3'h0, {8'h80, 72'h1234});
    op(OP_STORE_BCD, 2'h0, 1'b1, 1'b0, 3'h0, 3'h0, 80'h0);
    chk({core.got.data[79], 7'h0, core.got.data[71:0]}, {8'h80, 72'h1234});
    op(OP_LOAD_INT, FMT_LONG, 1'b0, 1'b0, 3'h0, 3'h0, 80'h7FFF_FFFF_FFFF_FFFF);
    op(OP_STORE_BCD, 2'h0, 1'b1, 1'b0, 3'h0, 3'h0, 80'h0);
    chk(core.got.data, BCD_INDEF);
    $display("test integer and decimal done");
    st(1'b1, cur);
    st(1'b1, FIVE);
    st(1'b1, HALF);
    chk({72'h0, tag_r}, 80'h0);
    $display("test drain done");
    report_and_stop();
  end
endmodule
